// File: hdl/clock_buffer_control.sv
// Control logic of a fifteen-output clock buffer: straps, power down, gating, bus slave
`timescale 1ns/1ns
module clock_buffer_control #(
  parameter int LOCK_CYCLES = ckbuf_pkg::LOCK_CYC,
  parameter int HOLD_CYCLES = ckbuf_pkg::HOLD_CYC
) (
  // Control clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  // Reference clock of the output stage
  input  wire logic                ref_clk_i,
  // Power good and straps
  input  wire logic                power_good_in_i,
  input  wire ckbuf_pkg::strap_s   strap_i,
  // Management bus, open drain
  input  wire logic                scl_i,
  output logic                     scl_o,
  output logic                     scl_oe_o,
  input  wire logic                mgmt_serial_data_i,
  output logic                     mgmt_serial_data_o,
  output logic                     mgmt_serial_data_oe_o,
  // Output gating, reference domain
  output logic [ckbuf_pkg::NUM_OUT-1:0] diff_clock_out_run_o,
  output logic                     feedback_clock_out_run_o,
  // PLL control
  output logic                     pll_on_o,
  output logic                     pll_bypass_o,
  output logic [1:0]               pll_mode_o,
  output logic                     freq_100m_o
);
  localparam int LOCK_LIM = ckbuf_pkg::LOCK_MAX_CYC;
  localparam int RES_LIM  = ckbuf_pkg::RESUME_MAX_CYC;

  typedef enum logic [2:0] {P_WAIT, P_LOCK, P_RUN, P_STOP, P_OFF} pwr_e;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_TXLD} slv_e;
  typedef enum logic [1:0] {K_ADDR, K_CMD, K_CNT, K_DATA} kind_e;

  // ==========================================================
  // Pin synchronisers, control domain
  // ==========================================================
  logic               pg_m1, pg_m2, pg_m3;
  ckbuf_pkg::strap_s  strap_m1, strap_m2, cfg;
  logic               st_m1, st_m2, ab_m1, ab_m2;
  logic               al_r2, all_stopped;  // Driven in the reference domain below
  logic [1:0]         b_s1, b_s2, b_h1, b_h2, b_f, b_fq;

  // Two flops before any logic; third flop only for edge finding
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pg_m1    <= 1'b0;
      pg_m2    <= 1'b0;
      pg_m3    <= 1'b0;
      strap_m1 <= '0;
      strap_m2 <= '0;
      st_m1    <= 1'b1;
      st_m2    <= 1'b1;
      ab_m1    <= 1'b0;
      ab_m2    <= 1'b0;
    end else begin
      pg_m1    <= power_good_in_i;
      pg_m2    <= pg_m1;
      pg_m3    <= pg_m2;
      strap_m1 <= strap_i;
      strap_m2 <= strap_m1;
      st_m1    <= all_stopped;
      st_m2    <= st_m1;
      ab_m1    <= al_r2;
      ab_m2    <= ab_m1;
    end
  end

  // Bus lines: sync, then hold until three samples agree
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b_s1 <= 2'h3;
      b_s2 <= 2'h3;
      b_h1 <= 2'h3;
      b_h2 <= 2'h3;
      b_f  <= 2'h3;
      b_fq <= 2'h3;
    end else begin
      b_s1 <= {mgmt_serial_data_i, scl_i};
      b_s2 <= b_s1;
      b_h1 <= b_s2;
      b_h2 <= b_h1;
      b_f  <= (b_s2 & b_h1 & b_h2) | (b_f & (b_s2 | b_h1 | b_h2));
      b_fq <= b_f;
    end
  end

  // ==========================================================
  // Power sequencing
  // ==========================================================
  pwr_e                   pstate;
  logic [ckbuf_pkg::CNT_W-1:0] cnt, age;
  logic                   relock, allow, go_lock, pg_rise, pd_now;
  logic [1:0]             next_mode;
  logic [7:0]             regs [ckbuf_pkg::REG_NUM];
  logic                   ovr_en;

  assign pg_rise = pg_m2 && !pg_m3;
  assign go_lock = (pstate == P_WAIT && pg_rise) || (pstate == P_OFF && pg_m2);
  assign pd_now  = (pstate != P_WAIT) && !pg_m2;
  assign ovr_en  = regs[0][ckbuf_pkg::B0_OVR_EN];

  // Power state machine; power down never reloads straps, only the first rise after reset does
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pstate   <= P_WAIT;
      cnt      <= '0;
      relock   <= 1'b0;
      allow    <= 1'b0;
      pll_on_o <= 1'b0;
      cfg      <= '0;
    end else begin
      case (pstate)
        P_WAIT: if (go_lock) begin
          cfg      <= strap_m2;
          cnt      <= ckbuf_pkg::CNT_W'(LOCK_CYCLES);
          relock   <= 1'b0;
          pll_on_o <= 1'b1;
          pstate   <= P_LOCK;
        end
        P_LOCK: if (!pg_m2) begin
          pstate <= P_STOP;
        end else if (cnt == '0) begin
          allow  <= 1'b1;
          pstate <= P_RUN;
        end else begin
          cnt <= cnt - 1'b1;
        end
        P_RUN: if (!pg_m2) begin
          allow  <= 1'b0;
          pstate <= P_STOP;
        end
        // VCO stays up until the reference side reports all gated
        P_STOP: if (st_m2 && !ab_m2) begin
          pll_on_o <= 1'b0;
          pstate   <= P_OFF;
        end
        P_OFF: if (go_lock) begin
          cnt      <= ckbuf_pkg::CNT_W'(ckbuf_pkg::RELOCK_CYC);
          relock   <= 1'b1;
          pll_on_o <= 1'b1;
          pstate   <= P_LOCK;
        end
        default: pstate <= P_WAIT;
      endcase
    end
  end

  // Mode applied only at lock entry, so an override waits for a restart
  always_comb begin
    if (ovr_en)
      next_mode = regs[0][ckbuf_pkg::B0_OVR_LO +: 2];
    else if (pstate == P_WAIT)
      next_mode = ckbuf_pkg::mode_of(strap_m2.pll);
    else
      next_mode = ckbuf_pkg::mode_of(cfg.pll);
  end

  // PLL mode, bypass route and frequency outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_mode_o   <= ckbuf_pkg::MODE_LBW;
      pll_bypass_o <= 1'b0;
      freq_100m_o  <= 1'b0;
      age          <= '0;
    end else begin
      if (go_lock) begin
        pll_mode_o   <= next_mode;
        pll_bypass_o <= (next_mode == ckbuf_pkg::MODE_BYP);
      end
      freq_100m_o <= cfg.freq;  // Reference passes 1:1
      age <= (pstate == P_LOCK) ? age + 1'b1 : '0;
    end
  end

  // ==========================================================
  // Reference domain: glitch-free gating
  // ==========================================================
  logic                        rr1, rr2, pg_r1, pg_r2, pg_r3, al_r1;
  logic                        keep_run;
  logic [ckbuf_pkg::NUM_OUT-1:0] en, en_r1, en_r2;

  assign en = {regs[3][1:0], regs[2][7:5], regs[2][3:0], regs[1][7], regs[1][5:1]};
  // Run while allowed and the pin was high in one of the last two samples
  assign keep_run = al_r2 && (pg_r2 || pg_r3);

  // Reset release synchroniser for this domain
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rr1 <= 1'b0;
      rr2 <= 1'b0;
    end else begin
      rr1 <= 1'b1;
      rr2 <= rr1;
    end
  end

  // Power-down pin and control levels sampled on rising edges
  always_ff @(posedge ref_clk_i or negedge rr2) begin
    if (!rr2) begin
      pg_r1 <= 1'b0;
      pg_r2 <= 1'b0;
      pg_r3 <= 1'b0;
      al_r1 <= 1'b0;
      al_r2 <= 1'b0;
      en_r1 <= '0;
      en_r2 <= '0;
    end else begin
      pg_r1 <= power_good_in_i;
      pg_r2 <= pg_r1;
      pg_r3 <= pg_r2;
      al_r1 <= allow;
      al_r2 <= al_r1;
      en_r1 <= en;
      en_r2 <= en_r1;
    end
  end

  // Gates change only on the falling edge, so no runt pulse leaves
  always_ff @(negedge ref_clk_i or negedge rr2) begin
    if (!rr2) begin
      all_stopped              <= 1'b1;
      diff_clock_out_run_o     <= '0;
      feedback_clock_out_run_o <= 1'b0;
    end else begin
      all_stopped              <= !keep_run;
      diff_clock_out_run_o     <= keep_run ? en_r2 : '0;
      feedback_clock_out_run_o <= keep_run;
    end
  end

  // ==========================================================
  // Management bus slave
  // ==========================================================
  slv_e        sst;
  kind_e       kind;
  logic [7:0]  sh, wr_dat, rd_byte, tx_byte, b0_view, wmask, own_addr;
  logic [3:0]  bitc;
  logic [6:0]  idx, wr_idx;
  logic [5:0]  bcnt;
  logic        rd, blk, tx_cnt, wr_stb, next_ack, od_zero;
  logic        scl_f, sda_f, scl_rise, scl_fall, bus_start, bus_stop;
  logic [ckbuf_pkg::HOLD_W-1:0] hold_cnt;

  assign scl_f     = b_f[0];
  assign sda_f     = b_f[1];
  assign scl_rise  = scl_f && !b_fq[0];
  assign scl_fall  = !scl_f && b_fq[0];
  assign bus_start = scl_f && b_fq[0] && b_fq[1] && !sda_f;
  assign bus_stop  = scl_f && b_fq[0] && !b_fq[1] && sda_f;
  assign b0_view   = regs[0] | {ckbuf_pkg::mode_of(cfg.pll), 6'h00}
                   | {7'h00, cfg.freq};
  assign rd_byte   = (idx == 7'h00) ? b0_view :
                     (idx < 7'(ckbuf_pkg::REG_NUM)) ? regs[idx[1:0]] : 8'h00;
  assign tx_byte   = tx_cnt ? ckbuf_pkg::BLK_RD_CNT : rd_byte;
  assign own_addr  = ckbuf_pkg::bus_addr(cfg.addr_hi, cfg.addr_lo);

  // Whether the byte just received earns an acknowledge
  always_comb begin
    case (kind)
      K_ADDR:  next_ack = (sh[7:1] == own_addr[7:1])
                          && (sh != ckbuf_pkg::GEN_CALL);
      K_CMD:   next_ack = 1'b1;
      K_CNT:   next_ack = (sh != 8'h00) && (sh <= ckbuf_pkg::BLK_MAX);
      K_DATA:  next_ack = (bcnt != 6'h00);
      default: next_ack = 1'b0;
    endcase
  end

  // Bit engine; samples at 20 MHz, ample for 100 and 400 kbps
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sst <= S_IDLE;
      kind <= K_ADDR;
      sh <= 8'h00;
      bitc <= 4'h0;
      idx <= 7'h00;
      bcnt <= 6'h00;
      rd <= 1'b0;
      blk <= 1'b0;
      tx_cnt <= 1'b0;
      wr_stb <= 1'b0;
      wr_idx <= 7'h00;
      wr_dat <= 8'h00;
      mgmt_serial_data_oe_o <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      // Let go one count early so the low time never passes the limit
      if (pd_now || bus_stop || hold_cnt >= ckbuf_pkg::HOLD_W'(HOLD_CYCLES - 1)) begin
        sst <= S_IDLE;
        mgmt_serial_data_oe_o <= 1'b0;
      end else if (bus_start) begin
        sst <= S_RX;
        kind <= K_ADDR;
        bitc <= 4'h0;
        mgmt_serial_data_oe_o <= 1'b0;
      end else begin
        case (sst)
          S_RX: if (scl_rise) begin
            sh <= {sh[6:0], sda_f};
            bitc <= bitc + 4'h1;
          end else if (scl_fall && bitc == ckbuf_pkg::BYTE_BITS) begin
            sst <= next_ack ? S_ACK : S_IDLE;
            mgmt_serial_data_oe_o <= next_ack;
            bitc <= 4'h0;
            if (next_ack) begin
              case (kind)
                K_ADDR: begin
                  rd <= sh[0];
                  tx_cnt <= blk;
                  kind <= sh[0] ? K_DATA : K_CMD;
                end
                K_CMD: begin
                  blk <= !sh[7];
                  idx <= sh[6:0];
                  bcnt <= 6'h01;
                  kind <= sh[7] ? K_DATA : K_CNT;
                end
                K_CNT: begin
                  bcnt <= sh[5:0];
                  kind <= K_DATA;
                end
                default: begin
                  wr_stb <= 1'b1;
                  wr_idx <= idx;
                  wr_dat <= sh;
                  idx <= idx + 7'h01;
                  bcnt <= bcnt - 6'h01;
                end
              endcase
            end
          end
          S_ACK, S_TXLD: if (scl_fall) begin
            if (rd) begin
              sst <= S_TX;
              sh <= tx_byte;
              mgmt_serial_data_oe_o <= !tx_byte[7];
              bitc <= 4'h1;
              tx_cnt <= 1'b0;
              if (!tx_cnt) idx <= idx + 7'h01;
            end else begin
              sst <= S_RX;
              mgmt_serial_data_oe_o <= 1'b0;
            end
          end
          S_TX: if (scl_fall) begin
            if (bitc == ckbuf_pkg::BYTE_BITS) begin
              sst <= S_TXACK;
              mgmt_serial_data_oe_o <= 1'b0;
            end else begin
              mgmt_serial_data_oe_o <= !sh[6];
              sh <= {sh[6:0], 1'b0};
              bitc <= bitc + 4'h1;
            end
          end
          S_TXACK: if (scl_rise) sst <= sda_f ? S_IDLE : S_TXLD;
          S_IDLE: sst <= S_IDLE;
          default: sst <= S_IDLE;
        endcase
      end
    end
  end

  // Low-hold watchdog and constant-low pad drive; clock is never stretched
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt <= '0;
      od_zero  <= 1'b0;
    end else begin
      hold_cnt <= mgmt_serial_data_oe_o ? hold_cnt + 1'b1 : '0;
      od_zero  <= 1'b0;
    end
  end
  assign scl_o              = od_zero;
  assign scl_oe_o           = od_zero;
  assign mgmt_serial_data_o = od_zero;

  // Write masks; override bits open only while bit 3 is already set
  always_comb begin
    case (wr_idx[1:0])
      2'h0:    wmask = ckbuf_pkg::B0_WMASK | (ovr_en ? ckbuf_pkg::B0_OVR_MASK : 8'h00);
      2'h1:    wmask = ckbuf_pkg::B1_WMASK;
      2'h2:    wmask = ckbuf_pkg::B2_WMASK;
      default: wmask = ckbuf_pkg::B3_WMASK;
    endcase
  end

  // Register file; power down does not touch it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regs[0] <= ckbuf_pkg::B0_RST;
      regs[1] <= ckbuf_pkg::B1_RST;
      regs[2] <= ckbuf_pkg::B2_RST;
      regs[3] <= ckbuf_pkg::B3_RST;
    end else if (wr_stb && wr_idx < 7'(ckbuf_pkg::REG_NUM)) begin
      regs[wr_idx[1:0]] <= (regs[wr_idx[1:0]] & ~wmask) | (wr_dat & wmask);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  strap_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pstate == P_WAIT && pg_rise) |=> (cfg == $past(strap_m2)))
    else $error("straps not latched at first power good");
  pd_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pstate == P_RUN && !pg_m2) |=> (!allow ##1 pstate == P_STOP || pstate == P_OFF))
    else $error("power down did not withdraw clocks");
  freq_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $changed(freq_100m_o) |-> (pstate == P_LOCK && !allow))
    else $error("frequency changed while outputs ran");
  pd_gate_a: assert property (@(negedge ref_clk_i) disable iff (!rr2)
    (!pg_r2 && !pg_r3) |=> (diff_clock_out_run_o == '0 && !feedback_clock_out_run_o))
    else $error("outputs not gated after power down");
  vco_order_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(pll_on_o) |-> $past(st_m2 && !ab_m2))
    else $error("VCO off before outputs stopped");
  fb_gate_a: assert property (@(negedge ref_clk_i) disable iff (!rr2)
    !feedback_clock_out_run_o |-> (diff_clock_out_run_o == '0))
    else $error("output runs without feedback");
  lock_time_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pstate == P_LOCK) |-> (age < LOCK_LIM))
    else $error("lock took too long");
  resume_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pstate == P_LOCK && relock) |-> (age < RES_LIM))
    else $error("resume took too long");
  bypass_map_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pll_bypass_o == (pll_mode_o == ckbuf_pkg::MODE_BYP))
    else $error("bypass route disagrees with mode");
  readback_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    b0_view[ckbuf_pkg::B0_MODE_LO +: 2] == ckbuf_pkg::mode_of(cfg.pll))
    else $error("mode readback not strap value");
  ovr_lock_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_stb && wr_idx == 7'h00 && !ovr_en) |=> $stable(regs[0][2:1]))
    else $error("override written while locked");
  hold_limit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !scl_oe_o && (hold_cnt <= ckbuf_pkg::HOLD_W'(HOLD_CYCLES)))
    else $error("bus line held too long");
  gen_call_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sst == S_RX && kind == K_ADDR && scl_fall && bitc == ckbuf_pkg::BYTE_BITS
     && sh == ckbuf_pkg::GEN_CALL && !pd_now && !bus_stop && !bus_start)
    |=> (sst == S_IDLE && !mgmt_serial_data_oe_o))
    else $error("general call acknowledged");
  pd_float_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pd_now |=> !mgmt_serial_data_oe_o)
    else $error("bus driven in power down");
endmodule

// File: hdl/ckbuf_pkg.sv
// Shared constants, codes and carriers of the clock buffer control block
package ckbuf_pkg;
  // Tri-level strap codes from the pad comparators
  localparam logic [1:0] TRI_LO  = 2'h0;
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_HI  = 2'h2;
  // PLL mode codes, also the readback field layout
  localparam logic [1:0] MODE_LBW = 2'h0;
  localparam logic [1:0] MODE_BYP = 2'h1;
  localparam logic [1:0] MODE_HBW = 2'h3;
  // Timing, figures in their own units, counts derived at 20 MHz
  localparam int MCLK_KHZ      = 20000;
  localparam int LOCK_MAX_US   = 1800;
  localparam int LOCK_US       = 1500;
  localparam int RESUME_MAX_US = 300;
  localparam int RELOCK_US     = 200;
  localparam int HOLD_MAX_MS   = 10;
  localparam int LOCK_MAX_CYC  = LOCK_MAX_US * MCLK_KHZ / 1000;
  localparam int LOCK_CYC      = LOCK_US * MCLK_KHZ / 1000;
  localparam int RESUME_MAX_CYC = RESUME_MAX_US * MCLK_KHZ / 1000;
  localparam int RELOCK_CYC    = RELOCK_US * MCLK_KHZ / 1000;
  localparam int HOLD_CYC      = HOLD_MAX_MS * MCLK_KHZ;
  // Sizes
  localparam int NUM_OUT  = 15;
  localparam int REG_NUM  = 4;
  localparam int CNT_W    = 16;
  localparam int HOLD_W   = 18;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Bus framing
  localparam logic [7:0] GEN_CALL   = 8'h00;
  localparam logic [7:0] BLK_MAX    = 8'h20;
  localparam logic [7:0] BLK_RD_CNT = 8'h04;
  // Byte 0 fields
  localparam int B0_FREQ   = 0;
  localparam int B0_OVR_LO = 1;
  localparam int B0_OVR_EN = 3;
  localparam int B0_MODE_LO = 6;
  localparam logic [7:0] B0_OVR_MASK = 8'h06;
  // Reset values and writable masks
  localparam logic [7:0] B0_RST = 8'h00;
  localparam logic [7:0] B1_RST = 8'hbe;
  localparam logic [7:0] B2_RST = 8'hef;
  localparam logic [7:0] B3_RST = 8'h03;
  localparam logic [7:0] B0_WMASK = 8'h08;
  localparam logic [7:0] B1_WMASK = 8'hbe;
  localparam logic [7:0] B2_WMASK = 8'hef;
  localparam logic [7:0] B3_WMASK = 8'h03;

  // Strap pins as sampled at power good
  typedef struct packed {
    logic       freq;
    logic [1:0] addr_hi;
    logic [1:0] addr_lo;
    logic [1:0] pll;
  } strap_s;

  // Tri-level pair to 8-bit bus address, write form
  function automatic logic [7:0] bus_addr(input logic [1:0] hi, input logic [1:0] lo);
    case ({hi, lo})
      {TRI_LO, TRI_LO}:   bus_addr = 8'hd8;
      {TRI_LO, TRI_MID}:  bus_addr = 8'hda;
      {TRI_LO, TRI_HI}:   bus_addr = 8'hde;
      {TRI_MID, TRI_LO}:  bus_addr = 8'hc2;
      {TRI_MID, TRI_MID}: bus_addr = 8'hc4;
      {TRI_MID, TRI_HI}:  bus_addr = 8'hc6;
      {TRI_HI, TRI_LO}:   bus_addr = 8'hca;
      {TRI_HI, TRI_MID}:  bus_addr = 8'hcc;
      {TRI_HI, TRI_HI}:   bus_addr = 8'hce;
      default:            bus_addr = 8'hd8;
    endcase
  endfunction

  // Tri-level strap to PLL mode code
  function automatic logic [1:0] mode_of(input logic [1:0] t);
    case (t)
      TRI_LO:  mode_of = MODE_LBW;
      TRI_MID: mode_of = MODE_BYP;
      default: mode_of = MODE_HBW;
    endcase
  endfunction
endpackage

// File: tb/ref_src.sv
// Reference clock source model feeding the output stage
`timescale 1ns/1ns
module ref_src (
  // Run request from the bench
  input  wire logic run_i,
  // Reference clock, 30 ns period
  output logic      ref_clk_o
);
  // ===========================================
  // Clock generation
  // Parks low while stopped, like a source that is switched off
  initial begin
    ref_clk_o = 1'h0;
    #7;
    forever begin
      #15 ref_clk_o = run_i & ~ref_clk_o;
    end
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench: straps, power down, output gating, bus access
`timescale 1ns/1ns
module testbench;
  logic              mclk_i, rst_n_i, pg, run_ref, sda_low, scl_low, ack;
  logic              scl_o, scl_oe, sda_o, sda_oe, pll_on, byp, f100, fb;
  logic [1:0]        mode;
  logic [14:0]       run;
  logic [7:0]        q;
  ckbuf_pkg::strap_s strap;
  wire               ref_clk, sda, scl;
  int                n_fail, total_checks, k;
  // ===========================================
  // Open-drain lines with pull-ups
  assign sda = ~(sda_low | sda_oe);
  assign scl = ~(scl_low | scl_oe);
  ref_src u_ref (.run_i(run_ref), .ref_clk_o(ref_clk));
  // Short lock count keeps the run brief; hold limit above five zero bits of a read
  clock_buffer_control #(.LOCK_CYCLES(100), .HOLD_CYCLES(2000)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ref_clk_i(ref_clk), .power_good_in_i(pg),
    .strap_i(strap), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .mgmt_serial_data_i(sda), .mgmt_serial_data_o(sda_o),
    .mgmt_serial_data_oe_o(sda_oe), .diff_clock_out_run_o(run),
    .feedback_clock_out_run_o(fb), .pll_on_o(pll_on), .pll_bypass_o(byp),
    .pll_mode_o(mode), .freq_100m_o(f100));
  // ===========================================
  // Helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task half;
    repeat (100) @(posedge mclk_i);
  endtask
  // One bit at 100 kbps; data moves well after the clock fall
  task bit_io(input logic b, output logic r);
    repeat (10) @(posedge mclk_i);
    sda_low <= ~b;
    half;
    scl_low <= 1'h0;
    half;
    r = sda;
    scl_low <= 1'h1;
  endtask
  task xbyte(input logic [7:0] d, output logic [7:0] v, output logic a);
    logic n;
    for (int i = 7; i >= 0; i--) bit_io(d[i], v[i]);
    bit_io(1'h1, n);
    a = ~n;
  endtask
  task start_c;
    sda_low <= 1'h0;
    half;
    scl_low <= 1'h0;
    half;
    sda_low <= 1'h1;
    half;
    scl_low <= 1'h1;
  endtask
  task stop_c;
    sda_low <= 1'h1;
    half;
    scl_low <= 1'h0;
    half;
    sda_low <= 1'h0;
    half;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ===========================================
  // Clock and watchdog
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (80000) @(posedge mclk_i);
    n_fail++;
    test_done;
  end
  // ===========================================
  // Test sequence
  initial begin
    {rst_n_i, pg, sda_low, scl_low, n_fail, total_checks} = '0;
    run_ref = 1'h1;
    strap = '{1'h1, ckbuf_pkg::TRI_LO, ckbuf_pkg::TRI_LO, ckbuf_pkg::TRI_MID};
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    repeat (20) @(posedge mclk_i);
    pg <= 1'h1;
    for (k = 0; k < 20 && pll_on !== 1'h1; k++) @(posedge mclk_i);
    chk(pll_on, 1'h1);
    @(posedge mclk_i);
    chk({byp, mode, f100}, {1'h1, ckbuf_pkg::MODE_BYP, 1'h1});
    // Straps moved after the latch must be ignored
    strap <= '{1'h0, ckbuf_pkg::TRI_HI, ckbuf_pkg::TRI_HI, ckbuf_pkg::TRI_HI};
    for (k = 0; k < 300 && fb !== 1'h1; k++) @(posedge mclk_i);
    chk({fb, run}, 16'hffff);
    // Byte write clears outputs 0 to 5
    start_c;
    xbyte(8'hd8, q, ack);
    chk(ack, 1'h1);
    xbyte(8'h81, q, ack);
    chk(ack, 1'h1);
    xbyte(8'h00, q, ack);
    chk(ack, 1'h1);
    stop_c;
    chk(run, 15'h7fc0);
    // Override refused while bit 3 is clear, then taken by a block write
    for (int j = 0; j < 2; j++) begin
      start_c;
      xbyte(8'hd8, q, ack);
      xbyte(j ? 8'h00 : 8'h80, q, ack);
      if (j) xbyte(8'h01, q, ack);
      chk(ack, 1'h1);
      xbyte(8'h0e, q, ack);
      chk(ack, 1'h1);
      stop_c;
    end
    // Byte read of byte 0 shows latched mode and frequency
    start_c;
    xbyte(8'hd8, q, ack);
    xbyte(8'h80, q, ack);
    start_c;
    xbyte(8'hd9, q, ack);
    chk(ack, 1'h1);
    xbyte(8'hff, q, ack);
    chk(q, 8'h4f);
    chk({scl_oe, scl_o, sda_o}, 3'h0);
    stop_c;
    // General call and a foreign address get no acknowledge
    for (int j = 0; j < 2; j++) begin
      start_c;
      xbyte(j ? 8'hc4 : 8'h00, q, ack);
      chk(ack, 1'h0);
      stop_c;
    end
    // Power down: gates drop before the VCO stops
    pg <= 1'h0;
    for (k = 0; k < 10 && run !== 15'h0; k++) @(posedge mclk_i);
    chk(pll_on, 1'h1);
    chk({fb, run}, 16'h0);
    repeat (20) @(posedge mclk_i);
    chk({pll_on, sda_oe}, 2'h0);
    run_ref <= 1'h0;
    repeat (50) @(posedge mclk_i);
    run_ref <= 1'h1;
    repeat (20) @(posedge mclk_i);
    pg <= 1'h1;
    for (k = 0; k < 6000 && fb !== 1'h1; k++) @(posedge mclk_i);
    chk({fb, run}, 16'hffc0);
    chk({byp, mode, f100}, {1'h0, ckbuf_pkg::MODE_HBW, 1'h1});
    test_done;
  end
endmodule
